// file: rtl/buck_fault_supervisor.sv
// turn-on sequencing, fault supervision and gate-drive control for a synchronous buck
`timescale 1ns/10ps
module buck_fault_supervisor
  import buck_sup_pkg::*;
#(
  parameter int unsigned BLANK_CYC   = FAULT_BLANK_CYC,
  parameter int unsigned MIN_WAIT_CYC = HICCUP_MIN_CYC,
  parameter int unsigned SS_REF_CYC  = TSS_REF_CYC
) (
  input  wire logic sys_clk_in,
  input  wire logic sys_rst_in,
  input  wire logic enable_above_in,
  input  wire logic deep_disable_in,
  input  wire logic vcc_uvlo_ok_in,
  input  wire logic vreg_uvlo_ok_in,
  input  wire logic soft_start_done_in,
  input  wire logic fb_overvoltage_in,
  input  wire logic fb_undervoltage_in,
  input  wire logic feedback_level_above_ref_in,
  input  wire logic external_overtemp_input_in,
  input  wire logic die_thermal_shutdown_in,
  input  wire logic lowside_current_trip_in,
  input  wire logic pwm_demand_in,
  input  wire logic high_side_gate_off_in,
  input  wire logic low_side_gate_off_in,
  input  wire logic limit_clamp_in,
  output logic      high_side_switch_out,
  output logic      low_side_switch_out,
  output logic      power_good_out,
  output logic      power_good_oe_out,
  output logic      soft_start_run_out,
  output logic      limit_fixed_sel_out,
  output logic      overcurrent_fault_out,
  output logic      overvoltage_fault_out,
  output logic      undervoltage_fault_out,
  output logic      hiccup_active_out
);
  typedef struct packed {
    sup_state_t       st;
    logic [PER_W-1:0] per_cnt;
    logic             hs_req;
    logic             hs;
    logic             ls;
    logic [LSB_W-1:0] ls_on_cnt;
    logic             hs_lock;
    logic             trip_seen;
    logic [1:0]       trip_cnt;
    logic [2:0]       backup_cnt;
    logic [CNT_W-1:0] ov_cnt;
    logic [CNT_W-1:0] uv_cnt;
    logic [CNT_W-1:0] tss_cnt;
    logic [CNT_W-1:0] tss_meas;
    logic [CNT_W-1:0] wait_cnt;
    logic             prebias_hold;
    logic             prebias_init;
    logic             pg_oe;
    logic             ocf;
    logic             ovf;
    logic             uvf;
    logic             clamp_sel;
    logic             ss_run;
    logic             hic;
  } sup_regs_t;

  localparam sup_regs_t RST_VAL = '{st: DEEP_OFF, pg_oe: 1'b1, default: '0};
  localparam logic [PER_W-1:0] PER_LAST   = PER_W'(SW_PERIOD_CYC - 1);
  localparam logic [PER_W-1:0] ON_LAST    = PER_W'(MAX_ON_CYC - 1);
  localparam logic [LSB_W-1:0] LS_BLANK   = LSB_W'(LS_BLANK_CYC);
  localparam logic [1:0]       TRIP_LAST  = 2'(TRIP_LIMIT - 1);
  localparam logic [2:0]       BACKUP_LAST = 3'(BACKUP_LIMIT - 1);
  localparam logic [CNT_W-1:0] CNT_MAX    = '1;

  sup_regs_t         q;
  sup_regs_t         n;
  logic [SYNC_W-1:0] raw;
  logic [SYNC_W-1:0] s;
  logic              en_s, deep_s, uvlo_a_s, uvlo_b_s, ssdone_s, ov_s, uv_s, fbref_s;
  logic              ot_s, tsd_s, trip_s, pwm_s, hs_off_s, ls_off_s, clamp_s;
  logic              new_per, trip_ev, ov_hit, uv_hit, go_ss, go_hic, sw_en, ls_req;
  logic              start_ok, thermal;

  assign raw = {enable_above_in, deep_disable_in, vcc_uvlo_ok_in, vreg_uvlo_ok_in,
                soft_start_done_in, fb_overvoltage_in, fb_undervoltage_in,
                feedback_level_above_ref_in, external_overtemp_input_in,
                die_thermal_shutdown_in, lowside_current_trip_in, pwm_demand_in,
                high_side_gate_off_in, low_side_gate_off_in, limit_clamp_in};

  level_sync #(
    .WIDTH (SYNC_W)
  ) u_sync (
    .sys_clk_in (sys_clk_in),
    .sys_rst_in (sys_rst_in),
    .async_in   (raw),
    .sync_out   (s)
  );

  assign {en_s, deep_s, uvlo_a_s, uvlo_b_s, ssdone_s, ov_s, uv_s, fbref_s,
          ot_s, tsd_s, trip_s, pwm_s, hs_off_s, ls_off_s, clamp_s} = s;

  assign start_ok = en_s && uvlo_a_s && uvlo_b_s;
  assign thermal  = ot_s || tsd_s;

  always_comb begin
    n       = q;
    go_ss   = 1'b0;
    go_hic  = 1'b0;
    // free-running oscillator; a new period begins when the count wraps
    n.per_cnt = (q.per_cnt == PER_LAST) ? '0 : q.per_cnt + 1'b1;
    new_per   = (q.per_cnt == '0);
    // voltage comparators must hold continuously through blanking
    n.ov_cnt = ov_s ? ((q.ov_cnt == CNT_MAX) ? q.ov_cnt : q.ov_cnt + 1'b1) : '0;
    n.uv_cnt = uv_s ? ((q.uv_cnt == CNT_MAX) ? q.uv_cnt : q.uv_cnt + 1'b1) : '0;
    ov_hit   = ov_s && (q.ov_cnt >= CNT_W'(BLANK_CYC));
    uv_hit   = uv_s && (q.uv_cnt >= CNT_W'(BLANK_CYC));
    // blanking restarts outside regulation so soft-start time never counts toward a fault
    if (q.st != RUN) begin
      n.ov_cnt = '0;
      n.uv_cnt = '0;
    end
    // low-side conduction timer, saturates at the blanking count
    if (!q.ls) begin
      n.ls_on_cnt = '0;
    end else if (q.ls_on_cnt != LS_BLANK) begin
      n.ls_on_cnt = q.ls_on_cnt + 1'b1;
    end
    // at most one counted trip per switching period
    trip_ev = q.ls && (q.ls_on_cnt == LS_BLANK) && trip_s && !q.trip_seen
              && (q.st == SOFT_START || q.st == RUN);
    // trip-free periods advance the backup counter while trip_cnt is not zero
    if (new_per) begin
      n.trip_seen = 1'b0;
      if (!q.trip_seen && q.trip_cnt != '0) begin
        if (q.backup_cnt == BACKUP_LAST) begin
          n.trip_cnt   = '0;
          n.backup_cnt = '0;
        end else begin
          n.backup_cnt = q.backup_cnt + 1'b1;
        end
      end
      if (!trip_s) begin
        n.hs_lock = 1'b0;
      end
    end
    // a trip wins over the period-start clears above
    if (trip_ev) begin
      n.trip_seen  = 1'b1;
      n.hs_lock    = 1'b1;
      n.backup_cnt = '0;
      n.trip_cnt   = q.trip_cnt + 1'b1;
    end
    // soft-start length is measured for the hiccup wait
    if (q.st == SOFT_START && q.tss_cnt != CNT_MAX) begin
      n.tss_cnt = q.tss_cnt + 1'b1;
    end
    if (q.st == SOFT_START && q.prebias_hold && fbref_s != q.prebias_init) begin
      n.prebias_hold = 1'b0;
    end
    if (q.wait_cnt != '0) begin
      n.wait_cnt = q.wait_cnt - 1'b1;
    end

    if (deep_s) begin
      n.st = DEEP_OFF;
    end else if (q.st == DEEP_OFF || !start_ok) begin
      n.st = IDLE;
    end else if (thermal) begin
      n.st = THERMAL_OFF;
    end else begin
      case (q.st)
        IDLE: begin
          go_ss = 1'b1;
        end
        THERMAL_OFF: begin
          go_ss = 1'b1;
        end
        SOFT_START: begin
          // only current trips are acted on here
          if (trip_ev && q.trip_cnt == TRIP_LAST) begin
            n.ocf  = 1'b1;
            go_hic = 1'b1;
          end else if (ssdone_s) begin
            n.st       = RUN;
            n.tss_meas = q.tss_cnt;
          end
        end
        RUN: begin
          if (trip_ev && q.trip_cnt == TRIP_LAST) begin
            n.ocf  = 1'b1;
            go_hic = 1'b1;
          end else if (ov_hit) begin
            n.ovf = 1'b1;
            n.st  = OV_CLAMP;
          end else if (uv_hit) begin
            n.uvf  = 1'b1;
            go_hic = 1'b1;
          end
        end
        OV_CLAMP: begin
          if (uv_s) begin
            go_hic = 1'b1;
          end
        end
        HICCUP: begin
          if (q.wait_cnt == '0) begin
            go_ss = 1'b1;
          end
        end
        default: begin
          n.st = IDLE;
        end
      endcase
    end

    if (go_ss) begin
      n.st           = SOFT_START;
      n.tss_cnt      = '0;
      n.prebias_hold = 1'b1;
      n.prebias_init = fbref_s;
      n.trip_cnt     = '0;
      n.backup_cnt   = '0;
      n.hs_lock      = 1'b0;
      n.ocf          = 1'b0;
      n.ovf          = 1'b0;
      n.uvf          = 1'b0;
    end
    if (go_hic) begin
      n.st = HICCUP;
      // short soft-start falls back to the fixed minimum wait
      if (q.tss_meas < CNT_W'(SS_REF_CYC)) begin
        n.wait_cnt = CNT_W'(MIN_WAIT_CYC);
      end else begin
        n.wait_cnt = CNT_W'(q.tss_meas * CNT_W'(HICCUP_SS_MULT));
      end
    end

    // gate drive, derived from the next state so faults act in the same edge
    sw_en = (n.st == SOFT_START && !n.prebias_hold) || n.st == RUN;
    if (!sw_en) begin
      n.hs_req = 1'b0;
    end else if (new_per) begin
      n.hs_req = pwm_s && !n.hs_lock;
    end else if (!pwm_s || q.per_cnt >= ON_LAST) begin
      n.hs_req = 1'b0;
    end
    ls_req = (sw_en && !n.hs_req) || n.st == OV_CLAMP;
    // each side waits until the other gate is sensed off
    n.hs = n.hs_req && ls_off_s && !q.ls;
    n.ls = ls_req && hs_off_s && !q.hs && !n.hs;
    n.pg_oe = !(n.st == RUN && !ov_s && !uv_s);
    n.clamp_sel = (n.st == DEEP_OFF) ? 1'b0 : (q.clamp_sel || clamp_s);
    n.ss_run    = (n.st == SOFT_START) || (n.st == RUN);
    n.hic       = (n.st == HICCUP);
  end

  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      q <= RST_VAL;
    end else begin
      q <= n;
    end
  end

  // the pin only ever pulls low; its level is made outside
  assign power_good_out         = 1'b0;
  assign high_side_switch_out   = q.hs;
  assign low_side_switch_out    = q.ls;
  assign power_good_oe_out      = q.pg_oe;
  assign soft_start_run_out     = q.ss_run;
  assign limit_fixed_sel_out    = q.clamp_sel;
  assign overcurrent_fault_out  = q.ocf;
  assign overvoltage_fault_out  = q.ovf;
  assign undervoltage_fault_out = q.uvf;
  assign hiccup_active_out      = q.hic;

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (sys_rst_in);

  ss_voltage_ignored_a: assert property (
    q.st == SOFT_START |=> q.st != OV_CLAMP && !q.uvf && !q.ovf)
    else $error("voltage fault acted on during soft-start");
  hiccup_drives_off_a: assert property (
    q.st == HICCUP |-> !q.hs && !q.ls && q.pg_oe)
    else $error("drive or power-good active in hiccup");
  hiccup_restart_a: assert property (
    q.st == HICCUP && q.wait_cnt == '0 && start_ok && !thermal && !deep_s
    |=> q.st == SOFT_START)
    else $error("hiccup did not restart soft-start");
  thermal_off_a: assert property (
    thermal && q.st == RUN && !deep_s && start_ok |=> q.st == THERMAL_OFF ##0 !q.hs && !q.ls)
    else $error("thermal event did not stop switching");
  ov_clamp_drive_a: assert property (
    q.st == OV_CLAMP |-> !q.hs && q.pg_oe)
    else $error("high side or power-good wrong in over-voltage clamp");
  no_overlap_a: assert property (
    !(q.hs && q.ls))
    else $error("both switch drives on");
  max_duty_a: assert property (
    q.hs |-> q.per_cnt >= PER_W'(1) && q.per_cnt <= ON_LAST)
    else $error("high side on outside allowed window");
  trip_blank_a: assert property (
    q.ls_on_cnt != LS_BLANK |=> q.trip_cnt <= $past(q.trip_cnt))
    else $error("trip sampled inside blanking");
  third_trip_a: assert property (
    trip_ev && q.trip_cnt == TRIP_LAST && !deep_s && start_ok && !thermal
    |=> q.st == HICCUP && q.ocf)
    else $error("third trip did not enter hiccup");
  hs_lock_hold_a: assert property (
    $rose(q.hs_req) |-> !q.hs_lock && $past(new_per))
    else $error("high side restarted while locked or mid-period");
  deep_hold_a: assert property (
    deep_s |=> q.st == DEEP_OFF ##0 !q.hs && !q.ls)
    else $error("deep disable not honoured");
  pg_release_a: assert property (
    !q.pg_oe |-> q.st == RUN)
    else $error("power-good released outside regulation");

  hiccup_seen_c: cover property (q.st == OV_CLAMP ##1 q.st == HICCUP);
  trip_hiccup_c: cover property (trip_ev && q.trip_cnt == TRIP_LAST);
  thermal_restart_c: cover property (q.st == THERMAL_OFF ##1 q.st == SOFT_START);
  run_reached_c: cover property (q.st == SOFT_START ##1 q.st == RUN);
endmodule

// file: rtl/buck_sup_pkg.sv
// constants and types shared by the buck fault supervisor
package buck_sup_pkg;
  // base clock
  localparam int CLK_PERIOD_NS    = 4;
  // switching oscillator
  localparam int SW_FREQ_KHZ      = 500;
  localparam int SW_PERIOD_CYC    = 1000000 / (SW_FREQ_KHZ * CLK_PERIOD_NS);
  localparam int MAX_DUTY_PCT     = 92;
  localparam int MAX_ON_CYC       = (SW_PERIOD_CYC * MAX_DUTY_PCT) / 100;
  // low-side current trip blanking, least time so rounded up
  localparam int LS_BLANK_NS      = 150;
  localparam int LS_BLANK_CYC     = (LS_BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // feedback over/under-voltage blanking
  localparam int FAULT_BLANK_US   = 20;
  localparam int FAULT_BLANK_CYC  = (FAULT_BLANK_US * 1000) / CLK_PERIOD_NS;
  // hiccup retry timing
  localparam int HICCUP_MIN_MS    = 4;
  localparam int HICCUP_MIN_CYC   = (HICCUP_MIN_MS * 1000000) / CLK_PERIOD_NS;
  localparam int TSS_REF_MS       = 1;
  localparam int TSS_REF_CYC      = (TSS_REF_MS * 1000000) / CLK_PERIOD_NS;
  localparam int HICCUP_SS_MULT   = 4;
  // trip counting
  localparam int TRIP_LIMIT       = 3;
  localparam int BACKUP_LIMIT     = 7;
  // widths
  localparam int PER_W            = 9;
  localparam int LSB_W            = 6;
  localparam int CNT_W            = 32;
  localparam int SYNC_W           = 15;

  typedef enum logic [2:0] {
    DEEP_OFF,
    IDLE,
    SOFT_START,
    RUN,
    OV_CLAMP,
    HICCUP,
    THERMAL_OFF
  } sup_state_t;
endpackage

// file: rtl/level_sync.sv
// two-stage synchroniser for a group of asynchronous comparator levels
`timescale 1ns/10ps
module level_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             sys_clk_in,
  input  wire logic             sys_rst_in,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } sync_state_t;

  sync_state_t q;
  sync_state_t d;

  // the first stage feeds only the second stage
  always_comb begin
    d        = q;
    d.meta   = async_in;
    d.stable = q.meta;
  end

  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign sync_out = q.stable;
endmodule

// file: verification/buck_fault_supervisor_tb_top.sv
// self-checking bench for the buck fault supervisor
`timescale 1ns/10ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin bad_count++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (e)); end end
`define WAIT_UNTIL(c, n) for (int w_ = 0; w_ < (n) && !(c); w_++) tick(1);
module buck_fault_supervisor_tb_top;
  import buck_sup_pkg::*;
  localparam int BLANK = 20;
  localparam int MINW  = 200;
  localparam int SSREF = 50;
  logic sys_clk_in = 1'b0, sys_rst_in = 1'b1, enable_above_in = 1'b0;
  logic deep_disable_in = 1'b1, vcc_uvlo_ok_in = 1'b0, vreg_uvlo_ok_in = 1'b0;
  logic soft_start_done_in = 1'b0, fb_overvoltage_in = 1'b0, fb_undervoltage_in = 1'b0;
  logic feedback_level_above_ref_in = 1'b0, external_overtemp_input_in = 1'b0;
  logic die_thermal_shutdown_in = 1'b0, lowside_current_trip_in = 1'b0;
  logic pwm_demand_in = 1'b0, limit_clamp_in = 1'b0;
  logic high_side_gate_off_in, low_side_gate_off_in, high_side_switch_out;
  logic low_side_switch_out, power_good_out, power_good_oe_out, soft_start_run_out;
  logic limit_fixed_sel_out, overcurrent_fault_out, overvoltage_fault_out;
  logic undervoltage_fault_out, hiccup_active_out, pg_pin;
  int   bad_count = 0, check_count = 0, cycles = 0, hic_cycles = 0;
  int   ss_t0 = 0, ss_len = 0, hs_run = 0, t = 0;

  buck_fault_supervisor #(.BLANK_CYC(BLANK), .MIN_WAIT_CYC(MINW), .SS_REF_CYC(SSREF))
    i_buck_fault_supervisor (.sys_clk_in, .sys_rst_in, .enable_above_in,
    .deep_disable_in, .vcc_uvlo_ok_in, .vreg_uvlo_ok_in, .soft_start_done_in,
    .fb_overvoltage_in, .fb_undervoltage_in, .feedback_level_above_ref_in,
    .external_overtemp_input_in, .die_thermal_shutdown_in, .lowside_current_trip_in,
    .pwm_demand_in, .high_side_gate_off_in, .low_side_gate_off_in, .limit_clamp_in,
    .high_side_switch_out, .low_side_switch_out, .power_good_out, .power_good_oe_out,
    .soft_start_run_out, .limit_fixed_sel_out, .overcurrent_fault_out,
    .overvoltage_fault_out, .undervoltage_fault_out, .hiccup_active_out);
  switch_stage_model #(.OFF_DLY(3)) i_switch_stage_model (.sys_clk_in,
    .high_side_switch_in(high_side_switch_out), .low_side_switch_in(low_side_switch_out),
    .power_good_in(power_good_out), .power_good_oe_in(power_good_oe_out),
    .high_side_gate_off_out(high_side_gate_off_in),
    .low_side_gate_off_out(low_side_gate_off_in), .power_good_pin_out(pg_pin));

  always #2 sys_clk_in = ~sys_clk_in;

  task automatic summarize();
    if (bad_count == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // ceiling well above the roughly 18k cycles the scenarios need
  always @(posedge sys_clk_in) begin
    cycles <= cycles + 1;
    if (hiccup_active_out) hic_cycles <= hic_cycles + 1;
    if (cycles == 60000) begin
      bad_count++;
      summarize();
    end
  end

  always @(negedge sys_clk_in) begin
    if (!sys_rst_in) begin
      `CHK(high_side_switch_out & low_side_switch_out, 1'b0)
      if (high_side_switch_out) begin
        hs_run++;
      end else if (hs_run > 0) begin
        `CHK(hs_run <= MAX_ON_CYC, 1'b1)
        hs_run = 0;
      end
    end
  end

  task automatic tick(int n);
    repeat (n) @(posedge sys_clk_in);
    #1;
  endtask

  task automatic start_run(int hold, bit wait_hs);
    `WAIT_UNTIL(soft_start_run_out, 4000)
    `CHK(soft_start_run_out, 1'b1)
    ss_t0 = cycles;
    tick(hold);
    `CHK({high_side_switch_out, pg_pin}, 2'b00)
    `CHK({overvoltage_fault_out, undervoltage_fault_out}, 2'b00)
    fb_overvoltage_in = 1'b0;
    fb_undervoltage_in = 1'b0;
    feedback_level_above_ref_in = ~feedback_level_above_ref_in;
    if (wait_hs) begin
      `WAIT_UNTIL(high_side_switch_out, 600)
      `CHK(high_side_switch_out, 1'b1)
    end
    soft_start_done_in = 1'b1;
    ss_len = cycles - ss_t0;
    tick(8);
    `CHK(pg_pin, 1'b1)
  endtask

  // bench count of soft-start cycles differs from the design's by a few edges
  task automatic hiccup_wait();
    int n = 0;
    int e;
    e = (ss_len < SSREF) ? MINW : HICCUP_SS_MULT * ss_len;
    soft_start_done_in = 1'b0;
    while (hiccup_active_out && n < 5000) begin
      tick(1);
      n++;
    end
    `CHK(n > e - 16 && n < e + 16, 1'b1)
  endtask

  task automatic t_ov();
    fb_overvoltage_in = 1'b1;
    tick(BLANK);
    `CHK(overvoltage_fault_out, 1'b0)
    `WAIT_UNTIL(overvoltage_fault_out, 20)
    `CHK({overvoltage_fault_out, high_side_switch_out, pg_pin}, 3'b100)
    `WAIT_UNTIL(low_side_switch_out, 10)
    `CHK(low_side_switch_out, 1'b1)
    fb_overvoltage_in = 1'b0;
    tick(40);
    `CHK({low_side_switch_out, hiccup_active_out}, 2'b10)
    fb_undervoltage_in = 1'b1;
    `WAIT_UNTIL(hiccup_active_out, 8)
    `CHK({hiccup_active_out, high_side_switch_out, low_side_switch_out, pg_pin}, 4'h8)
    fb_undervoltage_in = 1'b0;
    hiccup_wait();
  endtask

  task automatic t_uv();
    fb_undervoltage_in = 1'b1;
    tick(BLANK);
    `CHK({undervoltage_fault_out, hiccup_active_out}, 2'b00)
    `WAIT_UNTIL(hiccup_active_out, 20)
    `CHK({undervoltage_fault_out, hiccup_active_out}, 2'b11)
    fb_undervoltage_in = 1'b0;
    hiccup_wait();
  endtask

  task automatic t_thermal(bit die);
    start_run(5, 1'b0);
    die_thermal_shutdown_in = die;
    external_overtemp_input_in = !die;
    tick(5);
    soft_start_done_in = 1'b0;
    `CHK({high_side_switch_out, low_side_switch_out, pg_pin}, 3'b000)
    tick(600);
    `CHK({high_side_switch_out, low_side_switch_out, soft_start_run_out}, 3'b000)
    die_thermal_shutdown_in = 1'b0;
    external_overtemp_input_in = 1'b0;
    `WAIT_UNTIL(soft_start_run_out, 6)
    `CHK(soft_start_run_out, 1'b1)
  endtask

  // one low-side trip, d cycles into low-side conduction
  task automatic lsp(int d);
    `WAIT_UNTIL(high_side_switch_out, 600)
    tick(100);
    pwm_demand_in = 1'b0;
    `WAIT_UNTIL(low_side_switch_out, 20)
    tick(d);
    lowside_current_trip_in = 1'b1;
    tick(10);
    lowside_current_trip_in = 1'b0;
    pwm_demand_in = 1'b1;
    tick(8);
    `CHK(high_side_switch_out, 1'b0)
  endtask

  task automatic clean(int n);
    repeat (n) begin
      `WAIT_UNTIL(high_side_switch_out, 600)
      `WAIT_UNTIL(!high_side_switch_out, 600)
    end
  endtask

  initial begin
    tick(3);
    sys_rst_in = 1'b0;
    tick(6);
    `CHK({high_side_switch_out, low_side_switch_out, pg_pin}, 3'b000)
    enable_above_in = 1'b1;
    vcc_uvlo_ok_in = 1'b1;
    pwm_demand_in = 1'b1;
    tick(10);
    `CHK({soft_start_run_out, high_side_switch_out, low_side_switch_out}, 3'b000)
    deep_disable_in = 1'b0;
    limit_clamp_in = 1'b1;
    tick(10);
    `CHK(soft_start_run_out, 1'b0)
    `CHK(limit_fixed_sel_out, 1'b1)
    limit_clamp_in = 1'b0;
    vreg_uvlo_ok_in = 1'b1;
    fb_overvoltage_in = 1'b1;
    fb_undervoltage_in = 1'b1;
    start_run(100, 1'b1);
    `WAIT_UNTIL(!high_side_switch_out, 600)
    `WAIT_UNTIL(high_side_switch_out, 600)
    t = cycles;
    `WAIT_UNTIL(!high_side_switch_out, 600)
    `WAIT_UNTIL(high_side_switch_out, 600)
    `CHK(cycles - t, SW_PERIOD_CYC)
    t_ov();
    start_run(5, 1'b0);
    t_uv();
    t_thermal(1'b0);
    t_thermal(1'b1);
    start_run(5, 1'b0);
    t = hic_cycles;
    repeat (3) lsp(1);
    `CHK(hic_cycles == t, 1'b1)
    lsp(60);
    lsp(60);
    clean(9);
    lsp(60);
    clean(5);
    lsp(60);
    clean(5);
    `CHK(hic_cycles == t, 1'b1)
    lsp(60);
    `CHK({hiccup_active_out, overcurrent_fault_out}, 2'b11)
    summarize();
  end
endmodule

// file: verification/switch_stage_model.sv
// switch stage and power-good pin model facing the supervisor
`timescale 1ns/10ps
module switch_stage_model #(
  parameter int OFF_DLY = 3
) (
  input  wire logic sys_clk_in,
  input  wire logic high_side_switch_in,
  input  wire logic low_side_switch_in,
  input  wire logic power_good_in,
  input  wire logic power_good_oe_in,
  output logic      high_side_gate_off_out,
  output logic      low_side_gate_off_out,
  output logic      power_good_pin_out
);
  logic [OFF_DLY-1:0] hs_hist_q = '0;
  logic [OFF_DLY-1:0] ls_hist_q = '0;
  // a gate reads off only after its drive stayed low for the discharge time
  always @(posedge sys_clk_in) begin
    hs_hist_q <= {hs_hist_q[OFF_DLY-2:0], high_side_switch_in};
    ls_hist_q <= {ls_hist_q[OFF_DLY-2:0], low_side_switch_in};
  end
  assign high_side_gate_off_out = ~(high_side_switch_in | (|hs_hist_q));
  assign low_side_gate_off_out  = ~(low_side_switch_in | (|ls_hist_q));
  // open-drain line with an external pull-up
  assign power_good_pin_out = power_good_oe_in ? power_good_in : 1'b1;
endmodule
